// ===== rtl/timer16_normal_mode_control.v
// Control registers and sequencing for a 16-bit timer in normal mode.
// Assumes an APB master on sys_clk; counter and compare datapath live outside.
//
// Function
// - Prescale code picks divide 1 to 1024
// - Enable bit starts and stops timer
// - Override bits route channel waveform to pins
// - Auto-lock holds lock until enabled buffers valid
// - With auto-lock, lock stays cleared until next update
// - Without auto-lock only software changes lock
// - Normal and frequency modes update at top
// - PWM modes: period top, update bottom
// - Normal mode emits no waveform on pins
// - Forced values drive waveform while disabled
// - Halves bit selects two 8-bit timers
// - Writing one in clear register clears
// - Lock, direction read same both registers
// - Command codes: none, update, restart, reset
// - Command field always reads zero
// - Lock one blocks buffered register updates
// - Direction bit: zero up, one down
// - Writing one in set register sets
// - Buffer-valid set on write, cleared on update
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "timer16_ctrl_defs.vh"

module timer16_normal_mode_control (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [2:0]  compareBufferWrite,
  input  wire        cycleTopBufferWrite,
  input  wire        hwDirSet,
  input  wire        hwDirClear,
  input  wire [2:0]  waveformLevel,
  input  wire        atTop,
  input  wire        atBottom,
  output reg         countTick,
  output wire        timerEnabled,
  output wire        countDown,
  output wire        topSource,
  output wire        twoRamp,
  output wire        overflowEvent,
  output wire        updateCondition,
  output wire        bufferTransfer,
  output wire        restartCounter,
  output wire        hardResetTimer,
  output wire [2:0]  waveformPin,
  output wire [2:0]  waveformPinOverride,
  output wire        halvesMode
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        enable;
  reg [2:0]  prescaleSelect;
  reg [2:0]  channelPinOverride;
  reg        autoLock;
  reg [2:0]  waveformMode;
  reg [2:0]  forcedOutputValue;
  reg        halvesModeBit;
  reg        updateLock;
  reg        direction;
  reg [2:0]  compareBufferValid;
  reg        cycleTopBufferValid;
  reg [9:0]  prescaleCount;
  reg [1:0]  command;

  wire       busWrite;
  wire       busRead;
  wire [7:0] wbyte;
  reg        next_updateLock;
  reg        next_direction;
  reg [2:0]  next_compareBufferValid;
  reg        next_cycleTopBufferValid;
  reg        next_countTick;
  reg [1:0]  pointKind;
  reg        validPeriodTop;
  wire       allEnabledValid;
  wire       hwUpdate;
  wire       pwmFamily;
  wire       wrWaveCfg;
  wire       wrLockClear;
  wire       wrLockSet;
  wire       wrValidClear;
  wire       wrValidSet;
  wire       autoLockArm;
  reg  [9:0] tapMask;

  assign busWrite = psel & penable & pwrite;
  assign busRead  = psel & ~pwrite;
  assign wbyte    = pwdata[7:0];
  // Zero wait states; no unmapped fault, unmapped reads return zero
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Decoded for the status logic and auto-lock arm; control writes decode paddr again in their own case
  assign wrWaveCfg    = busWrite & (paddr == `OFF_WAVE_CFG);
  assign wrLockClear  = busWrite & (paddr == `OFF_CMD_LOCK_CLR);
  assign wrLockSet    = busWrite & (paddr == `OFF_CMD_LOCK_SET);
  assign wrValidClear = busWrite & (paddr == `OFF_BUFVALID_CLR);
  assign wrValidSet   = busWrite & (paddr == `OFF_BUFVALID_SET);
  // Switching auto-lock on arms the lock
  // Only the off-to-on write arms; rewriting it on keeps the lock state
  assign autoLockArm  = wrWaveCfg & wbyte[`BIT_AUTO_LOCK] & ~autoLock;

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  // Zero at reset
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      enable             <= 1'b0;
      prescaleSelect     <= 3'h0;
      channelPinOverride <= 3'h0;
      autoLock           <= 1'b0;
      waveformMode       <= `WM_NORMAL;
      forcedOutputValue  <= 3'h0;
      halvesModeBit      <= 1'b0;
      command            <= `CMD_NONE;
    end
    else
    begin
      // Command is a strobe, held one cycle only
      command <= `CMD_NONE;
      if (busWrite)
      begin
        case (paddr)
          `OFF_PRESCALE_EN:
          begin
            enable         <= wbyte[`BIT_ENABLE];
            prescaleSelect <= wbyte[`PRESCALE_HI:`PRESCALE_LO];
          end
          `OFF_WAVE_CFG:
          begin
            channelPinOverride <= wbyte[`PIN_OVR_HI:`PIN_OVR_LO];
            autoLock           <= wbyte[`BIT_AUTO_LOCK];
            waveformMode       <= wbyte[2:0];
          end
          `OFF_FORCED_OUT:   forcedOutputValue <= wbyte[2:0];
          `OFF_HALVES:       halvesModeBit <= wbyte[0];
          // Same command via clear or set
          `OFF_CMD_LOCK_CLR: command <= wbyte[`CMD_HI:`CMD_LO];
          `OFF_CMD_LOCK_SET: command <= wbyte[`CMD_HI:`CMD_LO];
          default:           command <= `CMD_NONE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Tick every 1,2,4,8,16,64,256,1024 clocks
  always @*
  begin
    // Tick when all low bits of the free counter are ones
    case (prescaleSelect)
      3'h0:    tapMask = `TAP_DIV1;
      3'h1:    tapMask = `TAP_DIV2;
      3'h2:    tapMask = `TAP_DIV4;
      3'h3:    tapMask = `TAP_DIV8;
      3'h4:    tapMask = `TAP_DIV16;
      3'h5:    tapMask = `TAP_DIV64;
      3'h6:    tapMask = `TAP_DIV256;
      default: tapMask = `TAP_DIV1024;
    endcase
    next_countTick = ((prescaleCount & tapMask) == tapMask);
  end

  always @(posedge sys_clk)
  begin
    if (reset || !enable || restartCounter)
    begin
      prescaleCount <= 10'h000;
      countTick     <= 1'b0;
    end
    else
    begin
      prescaleCount <= prescaleCount + 10'h001;
      countTick     <= next_countTick;
    end
  end

  // ----------------------------------------------------------------
  // Waveform mode decode
  // ----------------------------------------------------------------
  // Normal/frequency: top source, update at top
  // PWM: period top, update at bottom, overflow per code
  always @*
  begin
    validPeriodTop = 1'b1;
    case (waveformMode)
      `WM_NORMAL:        pointKind = `PT_TOP;
      `WM_FREQUENCY:     pointKind = `PT_TOP;
      `WM_ONE_RAMP:      pointKind = `PT_BOTTOM;
      `WM_TWO_RAMP_HIGH: pointKind = `PT_TOP;
      `WM_TWO_RAMP_BOTH: pointKind = `PT_BOTH;
      `WM_TWO_RAMP_LOW:  pointKind = `PT_BOTTOM;
      default:
      begin
        // Reserved codes produce no events
        pointKind      = `PT_NONE;
        validPeriodTop = 1'b0;
      end
    endcase
  end

  assign pwmFamily = (waveformMode == `WM_ONE_RAMP) || waveformMode[2] & validPeriodTop;
  assign topSource = (waveformMode == `WM_FREQUENCY) ? `TOP_FROM_COMPARE0 : `TOP_FROM_PERIOD;
  assign twoRamp   = waveformMode[2] & validPeriodTop;
  assign overflowEvent = enable &
    ((pointKind[0] & atTop) | (pointKind[1] & atBottom));
  // PWM updates at bottom, normal and frequency at top
  assign hwUpdate = enable & validPeriodTop &
    (pwmFamily ? atBottom : atTop);
  assign updateCondition = hwUpdate | (command == `CMD_UPDATE);
  assign bufferTransfer  = updateCondition & ~updateLock;
  assign restartCounter  = (command == `CMD_RESTART);
  assign hardResetTimer  = (command == `CMD_HARD_RESET) & ~enable;
  assign timerEnabled    = enable;
  assign halvesMode      = halvesModeBit;
  // Zero counts up, one counts down
  assign countDown       = direction;

  // ----------------------------------------------------------------
  // Waveform pins
  // ----------------------------------------------------------------
  // Forced values while stopped
  assign waveformPin = enable ? waveformLevel : forcedOutputValue;
  // Override only in frequency or PWM modes
  // Normal mode never reaches the pin
  // Pin direction is software's job at the port
  assign waveformPinOverride = channelPinOverride &
    {3{(waveformMode == `WM_FREQUENCY) | pwmFamily}};

  // ----------------------------------------------------------------
  // Lock, direction and buffer-valid status
  // ----------------------------------------------------------------
  assign allEnabledValid =
    ((compareBufferValid | ~channelPinOverride) == 3'h7);

  always @*
  begin
    next_updateLock          = updateLock;
    next_direction           = direction;
    next_compareBufferValid  = compareBufferValid;
    next_cycleTopBufferValid = cycleTopBufferValid;
    if (wrLockClear)
    begin
      if (wbyte[`BIT_LOCK]) next_updateLock = 1'b0;
      if (wbyte[`BIT_DIR])  next_direction  = 1'b0;
    end
    if (wrLockSet)
    begin
      if (wbyte[`BIT_LOCK]) next_updateLock = 1'b1;
      if (wbyte[`BIT_DIR])  next_direction  = 1'b1;
    end
    if (wrValidClear)
    begin
      next_compareBufferValid  = next_compareBufferValid & ~wbyte[3:1];
      next_cycleTopBufferValid = next_cycleTopBufferValid & ~wbyte[0];
    end
    if (wrValidSet)
    begin
      next_compareBufferValid  = next_compareBufferValid | wbyte[3:1];
      next_cycleTopBufferValid = next_cycleTopBufferValid | wbyte[0];
    end
    if (hwDirClear) next_direction = 1'b0;
    if (hwDirSet)   next_direction = 1'b1;
    if (updateCondition)
    begin
      next_compareBufferValid  = 3'h0;
      next_cycleTopBufferValid = 1'b0;
    end
    // Buffer write sets, winning over the clear
    next_compareBufferValid  = next_compareBufferValid | compareBufferWrite;
    next_cycleTopBufferValid = next_cycleTopBufferValid | cycleTopBufferWrite;
    // Auto-lock switched on sets the lock at once
    if (autoLockArm)
      next_updateLock = 1'b1;
    // Without auto-lock only writes above touch the lock
    if (autoLock)
    begin
      // Release once all enabled buffers valid
      if (updateLock && allEnabledValid)
        next_updateLock = 1'b0;
      // Relock at the update that transferred
      else if (!updateLock && updateCondition)
        next_updateLock = 1'b1;
    end
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      updateLock          <= 1'b0;
      direction           <= 1'b0;
      compareBufferValid  <= 3'h0;
      cycleTopBufferValid <= 1'b0;
    end
    else
    begin
      updateLock          <= next_updateLock;
      direction           <= next_direction;
      compareBufferValid  <= next_compareBufferValid;
      cycleTopBufferValid <= next_cycleTopBufferValid;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (reset)
      prdata <= 32'h00000000;
    else if (busRead && !penable)
    begin
      case (paddr)
        `OFF_PRESCALE_EN:  prdata <= {28'h0000000, prescaleSelect, enable};
        `OFF_WAVE_CFG:     prdata <= {25'h0000000, channelPinOverride, autoLock,
                                      waveformMode};
        `OFF_FORCED_OUT:   prdata <= {29'h00000000, forcedOutputValue};
        `OFF_HALVES:       prdata <= {31'h00000000, halvesModeBit};
        `OFF_CMD_LOCK_CLR: prdata <= {28'h0000000, 2'h0, updateLock, direction};
        `OFF_CMD_LOCK_SET: prdata <= {28'h0000000, 2'h0, updateLock, direction};
        `OFF_BUFVALID_CLR: prdata <= {28'h0000000, compareBufferValid,
                                      cycleTopBufferValid};
        `OFF_BUFVALID_SET: prdata <= {28'h0000000, compareBufferValid,
                                      cycleTopBufferValid};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // timer16_normal_mode_control

// ===== rtl/timer16_ctrl_defs.vh
// Constants for the 16-bit timer control block: offsets, fields, codes.
// Assumes inclusion by bare name from rtl files only.
`ifndef TIMER16_CTRL_DEFS_VH
`define TIMER16_CTRL_DEFS_VH
`define OFF_PRESCALE_EN     12'h000
`define OFF_WAVE_CFG        12'h004
`define OFF_FORCED_OUT      12'h008
`define OFF_HALVES          12'h00C
`define OFF_CMD_LOCK_CLR    12'h010
`define OFF_CMD_LOCK_SET    12'h014
`define OFF_BUFVALID_CLR    12'h018
`define OFF_BUFVALID_SET    12'h01C
`define BIT_ENABLE          0
`define PRESCALE_HI         3
`define PRESCALE_LO         1
`define BIT_AUTO_LOCK       3
`define PIN_OVR_HI          6
`define PIN_OVR_LO          4
`define CMD_HI              3
`define CMD_LO              2
`define BIT_LOCK            1
`define BIT_DIR             0
`define CMD_NONE            2'h0
`define CMD_UPDATE          2'h1
`define CMD_RESTART         2'h2
`define CMD_HARD_RESET      2'h3
`define WM_NORMAL           3'h0
`define WM_FREQUENCY        3'h1
`define WM_ONE_RAMP         3'h3
`define WM_TWO_RAMP_HIGH    3'h5
`define WM_TWO_RAMP_BOTH    3'h6
`define WM_TWO_RAMP_LOW     3'h7
`define TOP_FROM_PERIOD     1'h0
`define TOP_FROM_COMPARE0   1'h1
`define PT_TOP              2'h1
`define PT_BOTTOM           2'h2
`define PT_BOTH             2'h3
`define PT_NONE             2'h0
`define TAP_DIV1            10'h000
`define TAP_DIV2            10'h001
`define TAP_DIV4            10'h003
`define TAP_DIV8            10'h007
`define TAP_DIV16           10'h00F
`define TAP_DIV64           10'h03F
`define TAP_DIV256          10'h0FF
`define TAP_DIV1024         10'h3FF
`endif

// ===== dv/timer16_ctrl_asserts.sv
// Concurrent checks on the timer control block outputs.
// Assumes a bind onto the block; sees its ports only.
`timescale 1ns/1ps
module timer16_ctrl_checker (
  input logic        sys_clk,
  input logic        reset,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        atTop,
  input logic        atBottom,
  input logic        timerEnabled,
  input logic        topSource,
  input logic [2:0]  waveformLevel,
  input logic [2:0]  waveformPin,
  input logic [2:0]  waveformPinOverride,
  input logic        updateCondition,
  input logic        hardResetTimer,
  input logic        halvesMode
);
  // ----------------------------------------
  // Shadow of the mode register
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [7:0] cfg;
  logic       wr;
  logic       pwm;
  assign wr = psel && penable && pwrite;
  assign pwm = cfg[2:0] == 3'h3 || cfg[2:0] >= 3'h5;
  // Kept from bus traffic, never from internals
  always @(posedge sys_clk)
    if (reset)
      cfg <= 8'h00;
    else if (wr && paddr == 12'h004)
      cfg <= pwdata[7:0];
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_enable_bit: assert property (wr && paddr == 12'h000 |=> timerEnabled == $past(pwdata[0]))
    else $error("enable bit not taken");
  a_halves_bit: assert property (wr && paddr == 12'h00C |=> halvesMode == $past(pwdata[0]))
    else $error("halves bit not taken");
  a_override_mode: assert property (waveformPinOverride == ((cfg[2:0] == 3'h1 || pwm) ? cfg[6:4] : 3'h0))
    else $error("pin override wrong for mode");
  a_top_source: assert property (topSource == (cfg[2:0] == 3'h1))
    else $error("top source wrong for mode");
  a_top_update: assert property (timerEnabled && atTop && cfg[2:0] <= 3'h1 |-> updateCondition)
    else $error("no update at top");
  a_pwm_update: assert property (timerEnabled && atBottom && pwm |-> updateCondition)
    else $error("no update at bottom");
  a_run_level: assert property (timerEnabled |-> waveformPin == waveformLevel)
    else $error("running output not from generator");
  a_cmd_zero: assert property (psel && penable && !pwrite && paddr[11:3] == 9'h002 |-> prdata[3:2] == 2'h0)
    else $error("command field reads nonzero");
  a_update_cmd: assert property (wr && paddr == 12'h014 && pwdata[3:2] == 2'h1 |=> updateCondition)
    else $error("update command lost");
  a_hard_ignored: assert property (wr && paddr == 12'h014 && pwdata[3:2] == 2'h3 && timerEnabled |=> !hardResetTimer)
    else $error("hard reset while running");
endmodule // timer16_ctrl_checker

// ===== dv/timer16_normal_mode_control_bench.sv
// Self-checking bench for the timer control block over APB.
// Assumes the block answers with pready; counter datapath is stimulated here.
`timescale 1ns/1ps
module timer16_normal_mode_control_bench;
  logic        sys_clk, reset, psel, penable, pwrite, cycleTopBufferWrite;
  logic        hwDirSet, hwDirClear, atTop, atBottom, pready, pslverr, countTick;
  logic        timerEnabled, countDown, topSource, twoRamp, overflowEvent, halvesMode;
  logic        updateCondition, bufferTransfer, restartCounter, hardResetTimer;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0]  compareBufferWrite, waveformLevel, waveformPin, waveformPinOverride;
  int          errTotal, comparisons, nTick, nXfer, nHard, nRst, i, s;
  int          dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  logic [31:0] msk[4] = '{32'h0F, 32'h7F, 32'h07, 32'h01};
  localparam logic [7:0] updTop = 8'h03, ovfTop = 8'h63, updBot = 8'hE8, ovfBot = 8'hC8;
  localparam logic [7:0] ovrMask = 8'hEA, twoMask = 8'hE0;

  timer16_normal_mode_control DUT (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .compareBufferWrite, .cycleTopBufferWrite,
    .hwDirSet, .hwDirClear, .waveformLevel, .atTop, .atBottom, .countTick, .timerEnabled,
    .countDown, .topSource, .twoRamp, .overflowEvent, .updateCondition, .bufferTransfer,
    .restartCounter, .hardResetTimer, .waveformPin, .waveformPinOverride, .halvesMode);
  // ----------------------------------------
  // Clock, pulse counters, watchdog
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Non-blocking so snapshots at an edge never race
  always @(posedge sys_clk)
  begin
    nTick <= nTick + countTick;
    nXfer <= nXfer + bufferTransfer;
    nHard <= nHard + hardResetTimer;
    nRst <= nRst + restartCounter;
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    errTotal++;
    closeOut;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task closeOut;
    $display("mismatches %0d comparisons %0d", errTotal, comparisons);
    if (errTotal == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    errTotal += (n >= 64);
    if (n >= 64)
      closeOut;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, hwDirSet, hwDirClear, atTop, atBottom} = '0;
    {compareBufferWrite, cycleTopBufferWrite} = '0;
    waveformLevel = 3'h2;
    reset = 1'b1;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 9; i++)
      rd(12'(i * 4), 32'h0);
    for (i = 0; i < 4; i++)
    begin
      wr(12'(i * 4), 32'hFFFFFFFF);
      rd(12'(i * 4), msk[i]);
    end
    chk(halvesMode, 1'b1);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h0);
    wr(12'h00C, 32'h0);
    wr(12'h010, 32'h2);
    wr(12'h014, 32'h3);
    rd(12'h010, 32'h3);
    rd(12'h014, 32'h3);
    chk(countDown, 1'b1);
    s = nXfer;
    @(posedge sys_clk) compareBufferWrite <= 3'h7;
    @(posedge sys_clk) compareBufferWrite <= 3'h0;
    wr(12'h014, 32'h4);
    rd(12'h010, 32'h3);
    chk(nXfer - s, 0);
    wr(12'h010, 32'h3);
    rd(12'h010, 32'h0);
    wr(12'h014, 32'h4);
    rd(12'h018, 32'h0);
    chk(nXfer - s, 1);
    @(posedge sys_clk) hwDirSet <= 1'b1;
    @(posedge sys_clk) hwDirSet <= 1'b0;
    rd(12'h010, 32'h1);
    wr(12'h010, 32'h1);
    // Auto-lock with channel 0 enabled only
    wr(12'h004, 32'h18);
    rd(12'h010, 32'h2);
    @(posedge sys_clk) {compareBufferWrite, cycleTopBufferWrite} <= 4'h3;
    @(posedge sys_clk) {compareBufferWrite, cycleTopBufferWrite} <= 4'h0;
    rd(12'h018, 32'h3);
    rd(12'h010, 32'h0);
    wr(12'h014, 32'h4);
    rd(12'h010, 32'h2);
    rd(12'h018, 32'h0);
    wr(12'h004, 32'h0);
    wr(12'h010, 32'h2);
    wr(12'h008, 32'h5);
    @(negedge sys_clk) chk(waveformPin, 3'h5);
    wr(12'h000, 32'h1);
    @(negedge sys_clk) chk(waveformPin, 3'h2);
    // Hard reset only counts while stopped
    s = nHard;
    wr(12'h014, 32'hC);
    wr(12'h000, 32'h0);
    wr(12'h014, 32'hC);
    i = nRst;
    wr(12'h014, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk(nHard - s, 1);
    chk(nRst - i, 1);
    wr(12'h000, 32'h1);
    // Pin direction is software's job; bench sees only the override
    for (i = 0; i < 8; i++)
    begin
      wr(12'h004, 32'h70 | i);
      @(negedge sys_clk) chk(topSource, i == 1);
      chk(twoRamp, twoMask[i]);
      chk(waveformPinOverride, ovrMask[i] ? 3'h7 : 3'h0);
      @(posedge sys_clk) atTop <= 1'b1;
      @(negedge sys_clk) chk({updateCondition, overflowEvent}, {updTop[i], ovfTop[i]});
      @(posedge sys_clk) {atTop, atBottom} <= 2'h1;
      @(negedge sys_clk) chk({updateCondition, overflowEvent}, {updBot[i], ovfBot[i]});
      @(posedge sys_clk) atBottom <= 1'b0;
    end
    for (i = 0; i < 8; i++)
    begin
      wr(12'h000, 32'h0);
      wr(12'h000, 32'(i * 2 + 1));
      repeat (4) @(posedge sys_clk);
      s = nTick;
      repeat (2048) @(posedge sys_clk);
      chk(nTick - s, 2048 / dv[i]);
    end
    closeOut;
  end
endmodule // timer16_normal_mode_control_bench

bind timer16_normal_mode_control timer16_ctrl_checker chk_inst (.sys_clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .atTop, .atBottom, .timerEnabled, .topSource,
  .waveformLevel, .waveformPin, .waveformPinOverride, .updateCondition, .hardResetTimer,
  .halvesMode);
